// >>> tmi_tx_maint.sv
// transmit maintenance insertion for one link: report, bit messages, loop code,
// all ones/zeros, alignment slips and transmit timing selection
// assumes input bits arrive as single-cycle strobes at least two cycles apart
`timescale 1ns/100ps
module tmi_tx_maint #(
  parameter int SEC_CYCLES = tmi_pkg::TMI_SEC_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire tmi_pkg::tmi_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic t1_mode,
  input wire logic esf_format,
  input wire logic tx_master_mode,
  input wire logic tx_mux_mode,
  input wire logic e1_backplane_rate,
  input wire tmi_pkg::tmi_events_t events,
  input wire tmi_pkg::tmi_stream_t stream_in,
  output logic tx_bit,
  output logic tx_valid,
  output logic tx_buffer_used,
  output tmi_pkg::tmi_clk_src_t tx_clk_src
);
  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

  if (SEC_CYCLES < 2) begin : g_bad_sec
    $error("SEC_CYCLES must be at least 2");
  end

  tmi_pkg::tmi_state_t s_reg;
  tmi_pkg::tmi_state_t s_next;
  logic esf_ok;
  logic sec_tick;
  logic report_ok;
  logic dl_slot;
  logic ser_busy;
  logic ser_bit;
  logic bom_on;
  logic loop_on;
  logic loop_pos;
  logic [3:0] loop_len;
  logic [14:0] bom_vec;
  logic [95:0] prm_msg;
  logic cofa_toggle;
  logic ins_bit;
  tmi_pkg::tmi_pair_t new_pair;

  // crc-6 error grade from the count of one second
  function automatic logic [5:0] tmi_grade(input logic [9:0] n);
    tmi_grade = 6'h00;
    if (n == tmi_pkg::TMI_G1_CNT) begin
      tmi_grade[0] = 1'h1;
    end else if (n > tmi_pkg::TMI_G1_CNT && n <= tmi_pkg::TMI_G2_MAX) begin
      tmi_grade[1] = 1'h1;
    end else if (n > tmi_pkg::TMI_G2_MAX && n <= tmi_pkg::TMI_G3_MAX) begin
      tmi_grade[2] = 1'h1;
    end else if (n > tmi_pkg::TMI_G3_MAX && n <= tmi_pkg::TMI_G4_MAX) begin
      tmi_grade[3] = 1'h1;
    end else if (n > tmi_pkg::TMI_G4_MAX && n <= tmi_pkg::TMI_G5_MAX) begin
      tmi_grade[4] = 1'h1;
    end else if (n > tmi_pkg::TMI_G6_ABOVE) begin
      tmi_grade[5] = 1'h1;
    end
  endfunction

  // one status octet pair, octet 5 style in the low byte
  function automatic logic [15:0] tmi_pair_octets(input tmi_pkg::tmi_pair_t p,
                                                  input logic [7:0] ctl);
    logic [7:0] first;
    logic [7:0] second;
    first = {p.grade[2], p.lv, p.grade[3], ctl[tmi_pkg::TMI_PRM_U1],
             ctl[tmi_pkg::TMI_PRM_U2], p.grade[4], p.sl, p.grade[5]};
    second = {p.fe, p.se, ctl[tmi_pkg::TMI_PRM_LB], p.grade[0],
              ctl[tmi_pkg::TMI_PRM_R], p.grade[1], p.seq};
    tmi_pair_octets = {second, first};
  endfunction

  // mode qualifiers and capture of the finished second
  assign esf_ok = t1_mode && esf_format;
  assign sec_tick = (s_reg.sec_cnt == SEC_LAST);
  assign report_ok = s_reg.prm_ctl[tmi_pkg::TMI_PRM_EN] && esf_ok;
  assign new_pair.grade = tmi_grade(s_reg.crc_cnt);
  assign new_pair.se = s_reg.se;
  assign new_pair.fe = s_reg.fe;
  assign new_pair.lv = s_reg.lv;
  assign new_pair.sl = s_reg.sl;
  assign new_pair.seq = s_reg.seq;

  // report body: flag, address, tei, control and four status pairs, newest first
  assign prm_msg = {tmi_pair_octets(s_reg.hist[3], s_reg.prm_ctl),
                    tmi_pair_octets(s_reg.hist[2], s_reg.prm_ctl),
                    tmi_pair_octets(s_reg.hist[1], s_reg.prm_ctl),
                    tmi_pair_octets(s_reg.hist[0], s_reg.prm_ctl),
                    tmi_pkg::TMI_CTRL, tmi_pkg::TMI_TEI,
                    tmi_pkg::TMI_SAPI_HI, s_reg.prm_ctl[tmi_pkg::TMI_PRM_CR], 1'h0,
                    tmi_pkg::TMI_FLAG};

  // insertion qualifiers
  assign dl_slot = stream_in.valid && stream_in.dl && esf_ok;
  assign bom_on = esf_ok && (s_reg.bom_code[5:0] != tmi_pkg::TMI_BOM_ALL_ONES);
  assign bom_vec = {tmi_pkg::TMI_BOM_HEAD, s_reg.bom_code[5:0], 1'h0};
  assign loop_on = s_reg.loop_ctl[tmi_pkg::TMI_LOOP_EN] && t1_mode;
  assign loop_pos = stream_in.valid
                    && (s_reg.loop_ctl[tmi_pkg::TMI_LOOP_UNFRM] || !stream_in.fbit);
  assign loop_len = tmi_pkg::TMI_LOOP_MIN_LEN + {2'h0, s_reg.loop_ctl[1:0]};
  assign cofa_toggle = s_reg.maint[tmi_pkg::TMI_MAINT_COFA] != s_reg.cofa_prev;

  tmi_prm_serializer u_ser (
    .clk(clk),
    .resetn(resetn),
    .start(s_reg.msg_start),
    .advance(dl_slot),
    .msg(prm_msg),
    .busy(ser_busy),
    .cur_bit(ser_bit)
  );

  // bit chain: data link, then loop code, then all ones/zeros
  always_comb begin
    ins_bit = stream_in.data;
    if (dl_slot && ser_busy) begin
      ins_bit = ser_bit;
    end else if (dl_slot && bom_on) begin
      ins_bit = bom_vec[tmi_pkg::TMI_BOM_LAST - s_reg.bom_idx];
    end
    if (loop_on && loop_pos) begin
      ins_bit = s_reg.loop_pat[3'(loop_len - 4'h1 - {1'h0, s_reg.loop_idx})];
    end
    if (s_reg.maint[tmi_pkg::TMI_MAINT_ZEROS]) begin
      ins_bit = 1'h0;
    end else if (s_reg.maint[tmi_pkg::TMI_MAINT_ONES]) begin
      ins_bit = 1'h1;
    end
  end

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.msg_start = 1'h0;
    // register writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        tmi_pkg::TMI_OFS_MAINT: s_next.maint = reg_req.wdata;
        tmi_pkg::TMI_OFS_TIMING: s_next.timing = reg_req.wdata;
        tmi_pkg::TMI_OFS_LOOP_CTL: s_next.loop_ctl = reg_req.wdata;
        tmi_pkg::TMI_OFS_LOOP_PAT: s_next.loop_pat = reg_req.wdata;
        tmi_pkg::TMI_OFS_PRM_CTL: s_next.prm_ctl = reg_req.wdata;
        tmi_pkg::TMI_OFS_BOM_CODE: s_next.bom_code = reg_req.wdata;
        default: s_next.maint = s_reg.maint;
      endcase
    end
    // register reads, data in the following cycle only
    s_next.rdata = 8'h00;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        tmi_pkg::TMI_OFS_MAINT: s_next.rdata = s_reg.maint;
        tmi_pkg::TMI_OFS_TIMING: s_next.rdata = s_reg.timing;
        tmi_pkg::TMI_OFS_LOOP_CTL: s_next.rdata = s_reg.loop_ctl;
        tmi_pkg::TMI_OFS_LOOP_PAT: s_next.rdata = s_reg.loop_pat;
        tmi_pkg::TMI_OFS_PRM_CTL: s_next.rdata = s_reg.prm_ctl;
        tmi_pkg::TMI_OFS_BOM_CODE: s_next.rdata = s_reg.bom_code;
        tmi_pkg::TMI_OFS_STATUS: s_next.rdata = {1'h0, s_reg.seq, tx_clk_src,
                                                 tx_buffer_used, bom_on, ser_busy};
        default: s_next.rdata = 8'h00;
      endcase
    end
    // per-second event counting; an event on the boundary counts in the new second
    s_next.sec_cnt = sec_tick ? 32'h0000_0000 : s_reg.sec_cnt + 32'h0000_0001;
    if (sec_tick) begin
      s_next.crc_cnt = {9'h000, events.crc_error};
      s_next.lv = events.line_violation;
      s_next.fe = events.frame_err;
      s_next.se = events.severe_frame;
      s_next.sl = events.slip;
      if (report_ok) begin
        s_next.hist = {s_reg.hist[2:0], new_pair};
        s_next.seq = s_reg.seq + 2'h1;
        s_next.msg_start = !ser_busy;
      end
    end else begin
      if (events.crc_error && s_reg.crc_cnt != tmi_pkg::TMI_CNT_SAT) begin
        s_next.crc_cnt = s_reg.crc_cnt + 10'h001;
      end
      s_next.lv = s_reg.lv || events.line_violation;
      s_next.fe = s_reg.fe || events.frame_err;
      s_next.se = s_reg.se || events.severe_frame;
      s_next.sl = s_reg.sl || events.slip;
    end
    // bit-oriented message position, repeating while active
    if (!bom_on) begin
      s_next.bom_idx = 4'h0;
    end else if (dl_slot && !ser_busy) begin
      s_next.bom_idx = (s_reg.bom_idx == tmi_pkg::TMI_BOM_LAST) ? 4'h0
                       : s_reg.bom_idx + 4'h1;
    end
    // loop code position, wrapping at the code length
    if (!loop_on) begin
      s_next.loop_idx = 3'h0;
    end else if (loop_pos) begin
      s_next.loop_idx = ({1'h0, s_reg.loop_idx} == loop_len - 4'h1) ? 3'h0
                        : s_reg.loop_idx + 3'h1;
    end
    // alignment change: a toggle is never lost to a bit consuming the previous one
    s_next.cofa_prev = s_reg.maint[tmi_pkg::TMI_MAINT_COFA];
    if (stream_in.valid) begin
      s_next.cofa_pending = 1'h0;
    end
    if (cofa_toggle) begin
      s_next.cofa_pending = 1'h1;
    end
    // output stage with deletion or repetition
    s_next.out_valid = 1'h0;
    s_next.rep_pending = 1'h0;
    if (stream_in.valid) begin
      if (s_reg.cofa_pending && !s_reg.cofa_repeat) begin
        s_next.cofa_repeat = 1'h1;
      end else begin
        s_next.out_bit = ins_bit;
        s_next.out_valid = 1'h1;
        if (s_reg.cofa_pending) begin
          s_next.rep_pending = 1'h1;
          s_next.cofa_repeat = 1'h0;
        end
      end
    end else if (s_reg.rep_pending) begin
      s_next.out_valid = 1'h1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.bom_code <= tmi_pkg::TMI_RST_BOM_CODE;
    end else begin
      s_reg <= s_next;
    end
  end

  // transmit buffer use and clock source
  always_comb begin
    if (tx_master_mode && !tx_mux_mode) begin
      tx_buffer_used = 1'h0;
      tx_clk_src = s_reg.timing[tmi_pkg::TMI_TIMING_SEL] ? tmi_pkg::TMI_CLK_MASTER
                   : tmi_pkg::TMI_CLK_LINE;
    end else if (!tx_mux_mode && t1_mode && e1_backplane_rate) begin
      tx_buffer_used = 1'h1;
      tx_clk_src = tmi_pkg::TMI_CLK_MASTER;
    end else if (s_reg.timing[tmi_pkg::TMI_TIMING_SEL]) begin
      tx_buffer_used = 1'h1;
      tx_clk_src = tmi_pkg::TMI_CLK_MASTER;
    end else begin
      tx_buffer_used = 1'h0;
      tx_clk_src = tmi_pkg::TMI_CLK_BACKPLANE;
    end
  end

  // outputs
  assign reg_rdata = s_reg.rdata;
  assign tx_bit = s_reg.out_bit;
  assign tx_valid = s_reg.out_valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_REPORT_ONLY_ESF: assert property ($rose(ser_busy) |-> $past(report_ok, 2))
    else $error("report started outside enabled esf mode");
  AST_COUNTER_CLEAR: assert property (sec_tick |=> s_reg.crc_cnt == {9'h000, $past(events.crc_error)}
                                      && s_reg.lv == $past(events.line_violation))
    else $error("per-second counters not cleared at boundary");
  AST_SEQ_ADVANCE: assert property (sec_tick && report_ok |=> s_reg.seq == $past(s_reg.seq) + 2'h1
                                    && s_reg.hist[0].seq == $past(s_reg.seq))
    else $error("sequence count did not advance with the report");
  AST_GRADE_ONE: assert property (sec_tick && report_ok && s_reg.crc_cnt == 10'h001
                                  |=> s_reg.hist[0].grade == 6'h01)
    else $error("single crc error not graded first");
  AST_BOM_SUPPRESS: assert property (dl_slot && !ser_busy && !loop_on && s_reg.maint[1:0] == 2'h0
                                     && s_reg.bom_code[5:0] == 6'h3f && !s_reg.cofa_pending
                                     |=> tx_bit == $past(stream_in.data))
    else $error("data link changed with all-ones message code");
  AST_ZEROS_WIN: assert property (stream_in.valid && s_reg.maint[1] && !s_reg.cofa_pending
                                  |=> tx_valid && !tx_bit)
    else $error("all zeros not transmitted");
  AST_ONES: assert property (stream_in.valid && s_reg.maint[1:0] == 2'h1 && !s_reg.cofa_pending
                             |=> tx_valid && tx_bit)
    else $error("all ones not transmitted");
  AST_FRAMED_FBIT: assert property (stream_in.valid && stream_in.fbit && !stream_in.dl && loop_on
                                    && !s_reg.loop_ctl[3] && s_reg.maint[1:0] == 2'h0
                                    && !s_reg.cofa_pending |=> tx_bit == $past(stream_in.data))
    else $error("framed loop code altered the framing bit");
  AST_COFA_DELETE: assert property (stream_in.valid && s_reg.cofa_pending && !s_reg.cofa_repeat
                                    |=> !tx_valid)
    else $error("alignment change deletion missing");
  AST_COFA_REPEAT: assert property (stream_in.valid && s_reg.cofa_pending && s_reg.cofa_repeat
                                    ##1 !stream_in.valid |-> tx_valid ##1 tx_valid && $stable(tx_bit))
    else $error("alignment change repetition missing");
  AST_E1_RATE_BUFFER: assert property (!tx_master_mode && !tx_mux_mode && t1_mode && e1_backplane_rate
                                       |-> tx_buffer_used && tx_clk_src == tmi_pkg::TMI_CLK_MASTER)
    else $error("buffer not used at e1 backplane rate");
  AST_MASTER_BYPASS: assert property (tx_master_mode && !tx_mux_mode |-> !tx_buffer_used)
    else $error("buffer used in master mode");
endmodule // tmi_tx_maint

// >>> tmi_pkg.sv
// constants, field layouts and carrier types for the transmit maintenance insertion block
// assumes one 40 MHz clock and registers reached over a plain address/strobe port
// Contract
// - performance report goes out only in T1/J1 mode with extended superframe format.
// - count line violations, CRC-6 errors, framing errors, severe framing errors, slips per second.
// - with report enable set, build a report every second, send on data-link bits.
// - report is 14 octets, flag first, octet 1 first, bit 1 first.
// - command/response, R, U1, U2 and loopback bits come from report control bits.
// - sequence bits of each status pair form a modulo-4 count advancing per report.
// - event bits in octets 5 to 12 follow counted events, zero when none occurred.
// - CRC grades: 1, 2-5, 6-10, 11-100, 101-319, above 320 errors.
// - severe, framing, violation and slip bits set on one or more events.
// - bit-oriented messages go out only in T1/J1 mode with extended superframe.
// - bit-oriented message uses data-link bits as 11111110, six code bits, 0.
// - an all-ones six-bit message code suppresses the bit-oriented message.
// - loop code length from two-bit field, content from eight-bit field, sent when enabled.
// - framed loop code overwrites all 24 channels and keeps the framing bit.
// - unframed loop code overwrites the channels and the framing bit.
// - afterwards all ones or all zeros replace the stream; all zeros wins.
// - each toggle of the alignment-change bit causes one bit deletion or repetition.
// - master mode bypasses buffer; timing select picks line or internal master clock.
// - slave T1/J1 at E1 backplane rate always buffers; timing select ignored.
// - other slave modes with timing select one buffer against the internal master clock.
// - other slave modes with timing select zero bypass buffer, clock from backplane.
// - multiplexed mode follows the general slave timing select behaviour.
package tmi_pkg;
  // register offsets
  localparam logic [11:0] TMI_OFS_MAINT = 12'h06c;
  localparam logic [11:0] TMI_OFS_TIMING = 12'h070;
  localparam logic [11:0] TMI_OFS_LOOP_CTL = 12'h074;
  localparam logic [11:0] TMI_OFS_LOOP_PAT = 12'h075;
  localparam logic [11:0] TMI_OFS_PRM_CTL = 12'h07f;
  localparam logic [11:0] TMI_OFS_BOM_CODE = 12'h080;
  localparam logic [11:0] TMI_OFS_STATUS = 12'h081;
  // field positions
  localparam int TMI_MAINT_ONES = 0;
  localparam int TMI_MAINT_ZEROS = 1;
  localparam int TMI_MAINT_COFA = 2;
  localparam int TMI_TIMING_SEL = 0;
  localparam int TMI_LOOP_EN = 2;
  localparam int TMI_LOOP_UNFRM = 3;
  localparam int TMI_PRM_EN = 0;
  localparam int TMI_PRM_CR = 1;
  localparam int TMI_PRM_R = 2;
  localparam int TMI_PRM_U1 = 3;
  localparam int TMI_PRM_U2 = 4;
  localparam int TMI_PRM_LB = 5;
  // reset values
  localparam logic [7:0] TMI_RST_ZERO = 8'h00;
  localparam logic [7:0] TMI_RST_BOM_CODE = 8'h3f;
  // message content
  localparam logic [7:0] TMI_FLAG = 8'h7e;
  localparam logic [5:0] TMI_SAPI_HI = 6'h0e;
  localparam logic [7:0] TMI_TEI = 8'h01;
  localparam logic [7:0] TMI_CTRL = 8'h03;
  localparam logic [15:0] TMI_CRC_INIT = 16'hffff;
  localparam logic [15:0] TMI_CRC_POLY = 16'h8408;
  localparam logic [6:0] TMI_SER_FLAG_BITS = 7'h08;
  localparam logic [6:0] TMI_SER_FCS_FIRST = 7'h60;
  localparam logic [6:0] TMI_SER_LAST = 7'h6f;
  localparam logic [5:0] TMI_BOM_ALL_ONES = 6'h3f;
  localparam logic [7:0] TMI_BOM_HEAD = 8'hfe;
  localparam logic [3:0] TMI_BOM_LAST = 4'he;
  localparam logic [3:0] TMI_LOOP_MIN_LEN = 4'h5;
  // crc grade bounds
  localparam logic [9:0] TMI_G1_CNT = 10'h001;
  localparam logic [9:0] TMI_G2_MAX = 10'h005;
  localparam logic [9:0] TMI_G3_MAX = 10'h00a;
  localparam logic [9:0] TMI_G4_MAX = 10'h064;
  localparam logic [9:0] TMI_G5_MAX = 10'h13f;
  localparam logic [9:0] TMI_G6_ABOVE = 10'h140;
  localparam logic [9:0] TMI_CNT_SAT = 10'h3ff;
  // one-second interval
  localparam int TMI_SEC_MS = 1000;
  localparam int TMI_CLK_PERIOD_NS = 25;
  localparam int TMI_SEC_CYCLES = TMI_SEC_MS * 1000000 / TMI_CLK_PERIOD_NS;

  typedef enum logic [1:0] {TMI_CLK_LINE, TMI_CLK_MASTER, TMI_CLK_BACKPLANE} tmi_clk_src_t;
  typedef enum logic {TMI_SER_IDLE, TMI_SER_SEND} tmi_ser_st_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } tmi_reg_req_t;

  typedef struct packed {
    logic data;
    logic valid;
    logic fbit;
    logic dl;
  } tmi_stream_t;

  typedef struct packed {
    logic line_violation;
    logic crc_error;
    logic frame_err;
    logic severe_frame;
    logic slip;
  } tmi_events_t;

  typedef struct packed {
    logic [5:0] grade;
    logic se;
    logic fe;
    logic lv;
    logic sl;
    logic [1:0] seq;
  } tmi_pair_t;

  typedef struct packed {
    tmi_ser_st_t st;
    logic [6:0] idx;
    logic [15:0] crc;
    logic [95:0] msg;
  } tmi_ser_state_t;

  typedef struct packed {
    logic [7:0] maint;
    logic [7:0] timing;
    logic [7:0] loop_ctl;
    logic [7:0] loop_pat;
    logic [7:0] prm_ctl;
    logic [7:0] bom_code;
    logic [7:0] rdata;
    logic [31:0] sec_cnt;
    logic [9:0] crc_cnt;
    logic lv;
    logic fe;
    logic se;
    logic sl;
    logic [1:0] seq;
    tmi_pair_t [3:0] hist;
    logic msg_start;
    logic [3:0] bom_idx;
    logic [2:0] loop_idx;
    logic cofa_prev;
    logic cofa_pending;
    logic cofa_repeat;
    logic rep_pending;
    logic out_bit;
    logic out_valid;
  } tmi_state_t;
endpackage

// >>> tmi_prm_serializer.sv
// serializer for the performance report: octets 1-12 then a 16-bit check sequence
// assumes start arrives only while idle and advance marks one data-link bit slot
`timescale 1ns/100ps
module tmi_prm_serializer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic advance,
  input wire logic [95:0] msg,
  output logic busy,
  output logic cur_bit
);
  tmi_pkg::tmi_ser_state_t s_reg;
  tmi_pkg::tmi_ser_state_t s_next;

  // one check-sequence step, lsb-first reflected polynomial
  function automatic logic [15:0] tmi_crc_step(input logic [15:0] c, input logic d);
    tmi_crc_step = (c >> 1) ^ ((c[0] ^ d) ? tmi_pkg::TMI_CRC_POLY : 16'h0000);
  endfunction

  // bit 1 of each octet first, check sequence covers octets 2 to 12
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      tmi_pkg::TMI_SER_IDLE: begin
        if (start) begin
          s_next.st = tmi_pkg::TMI_SER_SEND;
          s_next.idx = 7'h00;
          s_next.crc = tmi_pkg::TMI_CRC_INIT;
          s_next.msg = msg;
        end
      end
      tmi_pkg::TMI_SER_SEND: begin
        if (advance) begin
          if (s_reg.idx < tmi_pkg::TMI_SER_FCS_FIRST) begin
            s_next.msg = s_reg.msg >> 1;
            if (s_reg.idx >= tmi_pkg::TMI_SER_FLAG_BITS) begin
              s_next.crc = tmi_crc_step(s_reg.crc, s_reg.msg[0]);
            end
          end else begin
            s_next.crc = s_reg.crc >> 1;
          end
          if (s_reg.idx == tmi_pkg::TMI_SER_LAST) begin
            s_next.st = tmi_pkg::TMI_SER_IDLE;
          end else begin
            s_next.idx = s_reg.idx + 7'h01;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // current bit: message body, then inverted check sequence
  assign busy = (s_reg.st == tmi_pkg::TMI_SER_SEND);
  assign cur_bit = (s_reg.idx < tmi_pkg::TMI_SER_FCS_FIRST) ? s_reg.msg[0] : ~s_reg.crc[0];

  AST_SER_LAST_BIT: assert property (@(posedge clk) disable iff (!resetn)
    busy && advance && s_reg.idx == tmi_pkg::TMI_SER_LAST |=> !busy)
    else $error("report not ended after its last bit");
  AST_SER_FLAG_FIRST: assert property (@(posedge clk) disable iff (!resetn)
    $rose(busy) |-> !cur_bit ##0 s_reg.idx == 7'h00)
    else $error("report did not open with flag bit 1");
endmodule // tmi_prm_serializer

// >>> tmi_bp_source.sv
// backplane source model: one bit every four cycles, a framing bit every sixteenth bit
// assumes the design samples stream_in on rising clk edges
`timescale 1ns/100ps
module tmi_bp_source (
  input wire logic clk,
  input wire logic resetn,
  output tmi_pkg::tmi_stream_t stream
);
  logic [6:0] cnt_reg;
  // four-cycle spacing keeps the minimum gap between bits; framing bit carries 0
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 7'h00;
      stream <= '0;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
      stream.valid <= (cnt_reg[1:0] == 2'h3);
      stream.fbit <= (cnt_reg[5:2] == 4'hf);
      stream.data <= (cnt_reg[5:2] != 4'hf) & cnt_reg[2];
      stream.dl <= (cnt_reg[5:2] == 4'hf) && cnt_reg[6]; // every second framing bit is data link
    end
  end
endmodule // tmi_bp_source

// >>> tb_top.sv
// self-checking bench for the transmit maintenance insertion block
// assumes the backplane source model drives the stream input
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  tmi_pkg::tmi_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic tx_master_mode = 1'b0;
  logic tx_mux_mode = 1'b0;
  logic e1_backplane_rate = 1'b0;
  tmi_pkg::tmi_stream_t stream_in;
  logic tx_bit;
  logic tx_valid;
  logic tx_buffer_used;
  tmi_pkg::tmi_clk_src_t tx_clk_src;
  logic fbit_d = 1'b0;
  logic dl_d = 1'b0;
  logic esf_format = 1'b1;
  tmi_pkg::tmi_events_t events = '0;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  tmi_tx_maint #(.SEC_CYCLES(200)) DUT (.clk(clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .t1_mode(1'b1), .esf_format(esf_format),
    .tx_master_mode(tx_master_mode), .tx_mux_mode(tx_mux_mode),
    .e1_backplane_rate(e1_backplane_rate), .events(events),
    .stream_in(stream_in), .tx_bit(tx_bit), .tx_valid(tx_valid),
    .tx_buffer_used(tx_buffer_used), .tx_clk_src(tx_clk_src));
  tmi_bp_source src (.clk(clk), .resetn(resetn), .stream(stream_in));
  // clock and cycle count
  always #12.5 clk = ~clk;
  // remember whether the bit now leaving was a framing or data-link bit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stream_in.valid) begin
      fbit_d <= stream_in.fbit;
      dl_d <= stream_in.dl;
    end
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] exp, input logic [7:0] got, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s exp %h got %h", $time, what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) reg_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) reg_req <= '0;
    #1 check(exp, reg_rdata, "read");
  endtask
  // watch 44 output bits, checking the last 40: channel bits against ch, framing bits against fb
  task automatic watch(input logic ch, input logic fb);
    int n = 0;
    while (n < 44) begin
      @(posedge clk);
      #1 if (tx_valid) begin
        if (n >= 4) check({7'h00, fbit_d ? fb : ch}, {7'h00, tx_bit}, "bit");
        n++;
      end
    end
  endtask
  // message pattern on the data link, then nothing outside extended superframe
  task automatic test_bom();
    logic [14:0] pat = {8'hfe, 6'h15, 1'b0};
    int n;
    wr(tmi_pkg::TMI_OFS_BOM_CODE, 8'h15);
    for (int p = 0; p < 2; p++) begin
      n = 0;
      while (n < 15) begin
        @(posedge clk);
        #1 if (tx_valid && dl_d) begin
          check({7'h00, pat[14 - n]}, {7'h00, tx_bit}, "message");
          n++;
        end
      end
      @(posedge clk) esf_format <= (p != 0);
      pat = 15'h0000;
    end
    wr(tmi_pkg::TMI_OFS_BOM_CODE, 8'h3f);
    $display("test bom done");
  endtask
  // each toggle of the alignment bit: one bit fewer, then one extra, in 64 cycles
  task automatic test_cofa();
    int k;
    for (int t = 0; t < 2; t++) begin
      wr(tmi_pkg::TMI_OFS_MAINT, (t == 0) ? 8'h04 : 8'h00);
      k = 0;
      repeat (64) begin
        @(posedge clk);
        #1 k += int'(tx_valid);
      end
      check((t == 0) ? 8'h0f : 8'h11, 8'(k), "slip count");
    end
    $display("test cofa done");
  endtask
  // one event of each kind in the first reported second; find octets 1 to 8 on the data link
  task automatic test_report();
    logic [63:0] sr = '0;
    logic hit = 1'b0;
    int n = 0;
    @(posedge clk) begin
      reg_req <= '{1'b1, 1'b0, tmi_pkg::TMI_OFS_PRM_CTL, 8'h03};
      events <= '1;
    end
    @(posedge clk) begin
      reg_req <= '0;
      events <= '0;
    end
    while (n < 80 && !hit) begin
      @(posedge clk);
      #1 if (tx_valid && dl_d) begin
        sr = {sr[62:0], tx_bit};
        hit = (sr == 64'h7e5c80c0420b0000);
        n++;
      end
    end
    check(8'h01, {7'h00, hit}, "report");
    wr(tmi_pkg::TMI_OFS_PRM_CTL, 8'h00);
    $display("test report done");
  endtask
  task automatic test_regs();
    rd(tmi_pkg::TMI_OFS_BOM_CODE, 8'h3f);
    rd(tmi_pkg::TMI_OFS_STATUS, 8'h10);
    rd(tmi_pkg::TMI_OFS_PRM_CTL, 8'h00);
    wr(tmi_pkg::TMI_OFS_PRM_CTL, 8'h3e);
    rd(tmi_pkg::TMI_OFS_PRM_CTL, 8'h3e);
    rd(12'h123, 8'h00);
    $display("test regs done");
  endtask
  task automatic test_override();
    wr(tmi_pkg::TMI_OFS_MAINT, 8'h01);
    watch(1'b1, 1'b1);
    wr(tmi_pkg::TMI_OFS_MAINT, 8'h03);
    watch(1'b0, 1'b0);
    wr(tmi_pkg::TMI_OFS_MAINT, 8'h00);
    $display("test override done");
  endtask
  task automatic test_loop();
    wr(tmi_pkg::TMI_OFS_LOOP_PAT, 8'h1f);
    wr(tmi_pkg::TMI_OFS_LOOP_CTL, 8'h0c);
    watch(1'b1, 1'b1);
    wr(tmi_pkg::TMI_OFS_LOOP_CTL, 8'h04);
    watch(1'b1, 1'b0);
    wr(tmi_pkg::TMI_OFS_LOOP_PAT, 8'h00);
    watch(1'b0, 1'b0);
    wr(tmi_pkg::TMI_OFS_LOOP_CTL, 8'h00);
    $display("test loop done");
  endtask
  // rows: master, mux, e1 rate, timing select, buffer used, two bits of clock source
  task automatic test_timing();
    logic [6:0] tbl [8] = '{7'b1000000, 7'b1001001, 7'b0010101, 7'b0011101,
                            7'b0001101, 7'b0000010, 7'b1100010, 7'b0111101};
    for (int i = 0; i < 8; i++) begin
      tx_master_mode <= tbl[i][6];
      tx_mux_mode <= tbl[i][5];
      e1_backplane_rate <= tbl[i][4];
      wr(tmi_pkg::TMI_OFS_TIMING, {7'h00, tbl[i][3]});
      #1 check({7'h00, tbl[i][2]}, {7'h00, tx_buffer_used}, "buffer");
      check({6'h00, tbl[i][1:0]}, {6'h00, tx_clk_src}, "clock");
    end
    $display("test timing done");
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    test_regs();
    test_override();
    test_loop();
    test_bom();
    test_cofa();
    test_report();
    test_timing();
    report_and_stop();
  end
endmodule // tb_top
